/* hdl/serial_line_polarity_status.sv */
// serial line block: register map switch, polarity, break length, pin direction
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "serial_defines.svh"
// Summary of operation
// - map bit 0: baud and control one
// - map bit 1: alternate status/controls there
// - transmit polarity inverts NRZ mark and space
// - infrared zero is short centred pulse
// - receive polarity mirrors transmit conventions
// - break is 10 or 13 bits
// - framing error check ignores break length
// - single wire: direction bit sets pin
// - low at first tick sets active
// - idle character clears active flag
module serial_line_polarity_status (
  // clock and reset
  input  wire logic                    core_clk_in,
  input  wire logic                    rstn_in,
  // register port
  input  wire serial_pkg::reg_req_type reg_req_in,
  output logic [7:0]                   reg_rdata_out,
  // serial pins
  input  wire logic                    txd_in,
  output logic                         txd_out,
  output logic                         txd_oe_out,
  input  wire logic                    rxd_in,
  // interrupt
  output logic                         irq_out
);
  import serial_pkg::*;

  // address compare, used by every write and read decode
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  // software registers
  logic [4:0]   baud_hi_q;     // divisor high bits
  logic [7:0]   baud_lo_q;     // divisor low bits
  logic [7:0]   ctrl_one_q;    // wire mode and format
  logic [7:0]   alt_ctrl1_q;   // alternate control one
  logic [7:0]   alt_ctrl2_q;   // alternate control two
  logic         alt_map_q;     // map select
  logic         tx_pol_q;      // transmit polarity
  logic         rx_pol_q;      // receive polarity
  logic         long_brk_q;    // long break select
  logic         pin_dir_q;     // single-wire pin direction
  logic [3:0]   irq_stat_q;    // sticky events
  logic [3:0]   irq_en_q;      // event enables
  logic         irq_q;         // interrupt output
  logic [7:0]   rdata_q;       // read data
  // transmitter
  tx_state_type tx_state_q;    // transmit state
  logic [9:0]   tx_shift_q;    // bits still to send, lsb first
  logic [3:0]   tx_bits_q;     // bits left in frame
  logic [3:0]   tx_tick_q;     // tick within bit
  logic         txd_q;         // pin level
  logic         txd_oe_q;      // pin enable
  // baud divider and infrared stretch
  logic [12:0]  div_cnt_q;     // divider count
  logic         tick_q;        // oversample enable pulse
  logic [4:0]   ir_hold_q;     // stretch ticks left after pulse
  // receiver results
  logic         rx_active;     // reception in progress
  rx_evt_type   rx_evt;        // receiver events
  logic         rx_line;       // normalised receive line, 1 = mark
  logic [7:0]   rx_data;       // last byte received

  // request decode
  wire       wr   = reg_req_in.wr;
  wire       rd   = reg_req_in.rd;
  wire [3:0] addr = reg_req_in.addr;
  wire [7:0] wd   = reg_req_in.wdata;
  wire wr_baud_hi  = wr & hit(addr, `OFF_SLOT0) & ~alt_map_q;
  wire wr_baud_lo  = wr & hit(addr, `OFF_SLOT1) & ~alt_map_q;
  wire wr_ctrl_one = wr & hit(addr, `OFF_SLOT2) & ~alt_map_q;
  wire wr_alt1     = wr & hit(addr, `OFF_SLOT1) & alt_map_q;
  wire wr_alt2     = wr & hit(addr, `OFF_SLOT2) & alt_map_q;
  wire wr_status2  = wr & hit(addr, `OFF_STATUS2);
  wire wr_data     = wr & hit(addr, `OFF_DATA);
  wire wr_cmd      = wr & hit(addr, `OFF_COMMAND);
  wire wr_irq_clr  = wr & hit(addr, `OFF_IRQ_CLR);
  wire wr_irq_en   = wr & hit(addr, `OFF_IRQ_EN);

  // mode decode
  wire one_wire  = ctrl_one_q[`BIT_ONE_WIRE];
  wire infrared  = ctrl_one_q[`BIT_INFRARED];
  wire tx_idle   = (tx_state_q == TX_IDLE);
  wire start_dat = wr_data & tx_idle;
  wire start_brk = wr_cmd & wd[`BIT_SEND_BRK] & tx_idle & ~wr_data;
  wire bit_end   = tick_q & (tx_tick_q == 4'hf);
  wire tx_done   = ~tx_idle & bit_end & (tx_bits_q == 4'h1);

  // status views
  wire [7:0] status2_val = {alt_map_q, 2'b00, tx_pol_q, rx_pol_q,
                            long_brk_q, pin_dir_q, rx_active};
  wire [7:0] alt_stat1   = {6'h00, ~tx_idle, rx_line};

  // read selection, the shared slots depend on the map bit
  wire [7:0] slot0_val = alt_map_q ? alt_stat1   : {3'h0, baud_hi_q};
  wire [7:0] slot1_val = alt_map_q ? alt_ctrl1_q : baud_lo_q;
  wire [7:0] slot2_val = alt_map_q ? alt_ctrl2_q : ctrl_one_q;
  wire [7:0] rd_val =
    hit(addr, `OFF_SLOT0)    ? slot0_val :
    hit(addr, `OFF_SLOT1)    ? slot1_val :
    hit(addr, `OFF_SLOT2)    ? slot2_val :
    hit(addr, `OFF_STATUS2)  ? status2_val :
    hit(addr, `OFF_DATA)     ? rx_data :
    hit(addr, `OFF_IRQ_STAT) ? {4'h0, irq_stat_q} :
    hit(addr, `OFF_IRQ_EN)   ? {4'h0, irq_en_q} : 8'h00;

  // transmit line level
  wire tx_bit   = tx_idle ? 1'b1 : tx_shift_q[0];
  wire nrz_lvl  = tx_bit ^ tx_pol_q;
  wire in_pulse = (tx_tick_q >= `IR_PULSE_LO) & (tx_tick_q <= `IR_PULSE_HI);
  wire ir_lvl   = (~tx_bit & ~tx_idle & in_pulse) ^ tx_pol_q;
  wire txd_d    = infrared ? ir_lvl : nrz_lvl;
  wire txd_oe_d = one_wire ? pin_dir_q : 1'b1;

  // receive line, normalised so that 1 is mark
  wire rx_pin  = one_wire ? txd_in : rxd_in;
  wire rx_norm = rx_pin ^ rx_pol_q;
  assign rx_line = infrared ? (~rx_norm & (ir_hold_q == 5'h00)) : rx_norm;

  // event set and clear, set wins
  wire [3:0] irq_set;
  assign irq_set[`IRQ_TX_DONE]   = tx_done;
  assign irq_set[`IRQ_RX_BYTE]   = rx_evt.byte_valid;
  assign irq_set[`IRQ_FRAME_ERR] = rx_evt.frame_err;
  assign irq_set[`IRQ_RX_IDLE]   = rx_evt.idle_seen;
  wire [3:0] irq_clr = wr_irq_clr ? wd[3:0] : 4'h0;

  // baud divider makes the oversample enable; divisor zero stops it
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_cnt_q <= 13'h0000;
      tick_q    <= 1'b0;
    end else begin
      tick_q    <= 1'b0;
      div_cnt_q <= div_cnt_q + 13'h0001;
      if (div_cnt_q >= {baud_hi_q, baud_lo_q} - 13'h0001) begin
        div_cnt_q <= 13'h0000;
        tick_q    <= ({baud_hi_q, baud_lo_q} != 13'h0000);
      end
    end
  end

  // configuration registers; the active flag bit is not writable
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      baud_hi_q   <= `BAUD_HI_RST;
      baud_lo_q   <= `BAUD_LO_RST;
      ctrl_one_q  <= `CTRL_RST;
      alt_ctrl1_q <= `CTRL_RST;
      alt_ctrl2_q <= `CTRL_RST;
      alt_map_q   <= 1'b0;
      tx_pol_q    <= 1'b0;
      rx_pol_q    <= 1'b0;
      long_brk_q  <= 1'b0;
      pin_dir_q   <= 1'b0;
      irq_en_q    <= 4'h0;
    end else begin
      if (wr_baud_hi) baud_hi_q <= wd[4:0];
      if (wr_baud_lo) baud_lo_q <= wd;
      if (wr_ctrl_one) ctrl_one_q <= wd;
      if (wr_alt1) alt_ctrl1_q <= wd;
      if (wr_alt2) alt_ctrl2_q <= wd;
      if (wr_irq_en) irq_en_q <= wd[3:0];
      if (wr_status2) begin
        alt_map_q  <= wd[`BIT_ALT_MAP];
        tx_pol_q   <= wd[`BIT_TX_POL];
        rx_pol_q   <= wd[`BIT_RX_POL];
        long_brk_q <= wd[`BIT_LONG_BRK];
        pin_dir_q  <= wd[`BIT_PIN_DIR];
      end
    end
  end

  // transmitter: data frame or break, one bit per sixteen ticks
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_state_q <= TX_IDLE;
      tx_shift_q <= 10'h3ff;
      tx_bits_q  <= 4'h0;
      tx_tick_q  <= 4'h0;
    end else begin
      case (tx_state_q)
        TX_IDLE: begin
          tx_tick_q <= 4'h0;
          if (start_dat) begin
            tx_shift_q <= {1'b1, wd, 1'b0};
            tx_bits_q  <= `FRAME_BITS;
            tx_state_q <= TX_SEND;
          end else if (start_brk) begin
            tx_shift_q <= 10'h000;
            tx_bits_q  <= long_brk_q ? `BRK_BITS_LONG : `BRK_BITS_SHORT;
            tx_state_q <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (tick_q) tx_tick_q <= tx_tick_q + 4'h1;
          if (bit_end) begin
            tx_shift_q <= {1'b0, tx_shift_q[9:1]};
            tx_bits_q  <= tx_bits_q - 4'h1;
            if (tx_bits_q == 4'h1) tx_state_q <= TX_IDLE;
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // pin drivers and infrared pulse stretch
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      txd_q     <= 1'b1;
      txd_oe_q  <= 1'b1;
      ir_hold_q <= 5'h00;
    end else begin
      txd_q    <= txd_d;
      txd_oe_q <= txd_oe_d;
      if (rx_norm) ir_hold_q <= 5'h10;
      else if (tick_q && ir_hold_q != 5'h00) ir_hold_q <= ir_hold_q - 5'h01;
    end
  end

  // interrupts, read data
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_stat_q <= 4'h0;
      irq_q      <= 1'b0;
      rdata_q    <= 8'h00;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      irq_q      <= |(irq_stat_q & irq_en_q);
      rdata_q    <= rd ? rd_val : 8'h00;
    end
  end

  // receiver
  serial_rx_core u_rx (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .tick_in     (tick_q),
    .line_in     (rx_line),
    .active_out  (rx_active),
    .evt_out     (rx_evt),
    .data_out    (rx_data)
  );

  assign txd_out       = txd_q;
  assign txd_oe_out    = txd_oe_q;
  assign reg_rdata_out = rdata_q;
  assign irq_out       = irq_q;

  property p_map0;
    @(posedge core_clk_in) disable iff (!rstn_in)
      (rd && hit(addr, `OFF_SLOT0) && !alt_map_q) |=> reg_rdata_out == {3'h0, $past(baud_hi_q)};
  endproperty
  a_map0: assert property (p_map0) else $error("slot0 not baud high");
  property p_map1;
    @(posedge core_clk_in) disable iff (!rstn_in)
      (rd && hit(addr, `OFF_SLOT1) && alt_map_q) |=> reg_rdata_out == $past(alt_ctrl1_q);
  endproperty
  a_map1: assert property (p_map1) else $error("slot1 not alternate one");
  property p_nrz_idle;
    @(posedge core_clk_in) disable iff (!rstn_in)
      (!infrared && tx_idle) |=> txd_out == !$past(tx_pol_q);
  endproperty
  a_nrz_idle: assert property (p_nrz_idle) else $error("nrz idle level wrong");
  property p_ir_one;
    @(posedge core_clk_in) disable iff (!rstn_in)
      (infrared && tx_bit) |=> txd_out == $past(tx_pol_q);
  endproperty
  a_ir_one: assert property (p_ir_one) else $error("infrared idle level wrong");
  property p_brk_len;
    @(posedge core_clk_in) disable iff (!rstn_in)
      start_brk |=> tx_bits_q == ($past(long_brk_q) ? 4'hd : 4'ha) && tx_shift_q == 10'h000;
  endproperty
  a_brk_len: assert property (p_brk_len) else $error("break length wrong");
  property p_dir;
    @(posedge core_clk_in) disable iff (!rstn_in)
      one_wire |=> txd_oe_out == $past(pin_dir_q);
  endproperty
  a_dir: assert property (p_dir) else $error("single-wire direction wrong");
  property p_dir_off;
    @(posedge core_clk_in) disable iff (!rstn_in)
      !one_wire |=> txd_oe_out;
  endproperty
  a_dir_off: assert property (p_dir_off) else $error("pin not driven");
  property p_act_ro;
    @(posedge core_clk_in) disable iff (!rstn_in)
      (wr_status2 && !wd[0] && rx_active && !rx_evt.idle_seen && !u_rx.idle_hit)
        |=> rx_active;
  endproperty
  a_act_ro: assert property (p_act_ro) else $error("active flag written");
  // register map views
  property p_map2;
    @(posedge core_clk_in) disable iff (!rstn_in)
      (rd && hit(addr, `OFF_SLOT2) && alt_map_q) |=> reg_rdata_out == $past(alt_ctrl2_q);
  endproperty
  a_map2: assert property (p_map2) else $error("slot2 not alternate two");
  property p_ctl1;
    @(posedge core_clk_in) disable iff (!rstn_in)
      (rd && hit(addr, `OFF_SLOT2) && !alt_map_q) |=> reg_rdata_out == $past(ctrl_one_q);
  endproperty
  a_ctl1: assert property (p_ctl1) else $error("slot2 not control one");
  property p_hide;
    @(posedge core_clk_in) disable iff (!rstn_in)
      (wr && hit(addr, `OFF_SLOT0) && alt_map_q) |=> $stable(baud_hi_q);
  endproperty
  a_hide: assert property (p_hide) else $error("hidden baud high written");
  // status view check
  property p_stat_rd;
    @(posedge core_clk_in) disable iff (!rstn_in)
      (rd && hit(addr, `OFF_STATUS2)) |=> reg_rdata_out[`BIT_RX_ACT] == $past(rx_active);
  endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("active flag not read back");
  // line level checks
  property p_nrz_bit;
    @(posedge core_clk_in) disable iff (!rstn_in)
      (!infrared && !tx_idle) |=> txd_out == ($past(tx_bit) ^ $past(tx_pol_q));
  endproperty
  a_nrz_bit: assert property (p_nrz_bit) else $error("nrz data level wrong");
  property p_ir_pulse;
    @(posedge core_clk_in) disable iff (!rstn_in)
      (infrared && !tx_idle && !tx_bit && in_pulse) |=> txd_out == !$past(tx_pol_q);
  endproperty
  a_ir_pulse: assert property (p_ir_pulse) else $error("infrared pulse level wrong");
  property p_ir_gap;
    @(posedge core_clk_in) disable iff (!rstn_in)
      (infrared && !in_pulse) |=> txd_out == $past(tx_pol_q);
  endproperty
  a_ir_gap: assert property (p_ir_gap) else $error("infrared rest level wrong");
  property p_rx_pol;
    @(posedge core_clk_in) disable iff (!rstn_in)
      (!infrared && !one_wire) |-> rx_line == (rxd_in ^ rx_pol_q);
  endproperty
  a_rx_pol: assert property (p_rx_pol) else $error("receive polarity wrong");
endmodule // serial_line_polarity_status

/* hdl/serial_defines.svh */
// register offsets, field positions, reset values and timing counts
`ifndef SERIAL_DEFINES_SVH
`define SERIAL_DEFINES_SVH
// register offsets (4-bit address)
`define OFF_SLOT0      4'h0
`define OFF_SLOT1      4'h1
`define OFF_SLOT2      4'h2
`define OFF_STATUS2    4'h3
`define OFF_DATA       4'h4
`define OFF_COMMAND    4'h5
`define OFF_IRQ_STAT   4'h6
`define OFF_IRQ_CLR    4'h7
`define OFF_IRQ_EN     4'h8
// status-two field positions
`define BIT_ALT_MAP    7
`define BIT_TX_POL     4
`define BIT_RX_POL     3
`define BIT_LONG_BRK   2
`define BIT_PIN_DIR    1
`define BIT_RX_ACT     0
// control-one fields and command bits
`define BIT_ONE_WIRE   0
`define BIT_INFRARED   1
`define BIT_SEND_BRK   0
// interrupt status bits
`define IRQ_TX_DONE    0
`define IRQ_RX_BYTE    1
`define IRQ_FRAME_ERR  2
`define IRQ_RX_IDLE    3
// reset values
`define BAUD_HI_RST    5'h00
`define BAUD_LO_RST    8'h04
`define CTRL_RST       8'h00
// timing counts, in oversample ticks or bits
`define OVERSAMPLE     16
`define MID_TICK       4'h7
`define IR_PULSE_LO    4'h6
`define IR_PULSE_HI    4'h8
`define FRAME_BITS     4'ha
`define BRK_BITS_SHORT 4'ha
`define BRK_BITS_LONG  4'hd
`define IDLE_TICKS     8'ha0
`endif

/* hdl/serial_pkg.sv */
// types shared by the serial status block and its receiver
package serial_pkg;
  // one register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_type;
  // one-cycle receiver events
  typedef struct packed {
    logic byte_valid;
    logic frame_err;
    logic idle_seen;
  } rx_evt_type;
  // receiver and transmitter states
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;
  typedef enum logic {TX_IDLE, TX_SEND} tx_state_type;
endpackage

/* hdl/serial_rx_core.sv */
// oversampling receiver with start search, activity flag and idle detect
`timescale 1ns/1ps
`include "serial_defines.svh"
module serial_rx_core (
  // clock and reset
  input  wire logic                    core_clk_in,
  input  wire logic                    rstn_in,
  // sample tick and normalised line (1 = mark)
  input  wire logic                    tick_in,
  input  wire logic                    line_in,
  // results
  output logic                         active_out,
  output serial_pkg::rx_evt_type       evt_out,
  output logic [7:0]                   data_out
);
  import serial_pkg::*;
  rx_state_type state_q;        // receiver state
  logic [3:0]   tick_cnt_q;     // ticks within bit
  logic [2:0]   bit_idx_q;      // data bit index
  logic [7:0]   shift_q;        // data shift register
  logic [7:0]   idle_cnt_q;     // consecutive mark ticks
  logic         active_q;       // reception in progress
  rx_evt_type   evt_q;          // event pulses
  // decode
  wire mid       = tick_in & (tick_cnt_q == `MID_TICK);
  wire first_low = tick_in & (state_q == RX_IDLE) & ~line_in;
  wire idle_hit  = tick_in & line_in & (idle_cnt_q == `IDLE_TICKS - 8'h01);
  // bit framing: sixteen ticks per bit, sampled in the middle
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q    <= RX_IDLE;
      tick_cnt_q <= 4'h0;
      bit_idx_q  <= 3'h0;
      shift_q    <= 8'h00;
    end else begin
      if (tick_in) begin
        tick_cnt_q <= tick_cnt_q + 4'h1;
      end
      case (state_q)
        RX_IDLE: begin
          if (first_low) begin
            state_q    <= RX_START;
            tick_cnt_q <= 4'h1;
          end
        end
        RX_START: begin
          if (mid) begin
            // false start goes back to searching
            state_q   <= line_in ? RX_IDLE : RX_DATA;
            bit_idx_q <= 3'h0;
          end
        end
        RX_DATA: begin
          if (mid) begin
            shift_q   <= {line_in, shift_q[7:1]};
            bit_idx_q <= bit_idx_q + 3'h1;
            if (bit_idx_q == 3'h7) begin
              state_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (mid) begin
            state_q <= RX_IDLE;
          end
        end
        default: state_q <= RX_IDLE;
      endcase
    end
  end
  // events and activity; the set beats the clear
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      idle_cnt_q <= 8'h00;
      active_q   <= 1'b0;
      evt_q      <= '0;
    end else begin
      if (tick_in) begin
        idle_cnt_q <= !line_in ? 8'h00 :
                      (idle_cnt_q == `IDLE_TICKS) ? idle_cnt_q : idle_cnt_q + 8'h01;
      end
      if (first_low) begin
        active_q <= 1'b1;
      end else if (idle_hit) begin
        active_q <= 1'b0;
      end
      evt_q.byte_valid <= mid & (state_q == RX_STOP);
      evt_q.frame_err  <= mid & (state_q == RX_STOP) & ~line_in;
      evt_q.idle_seen  <= idle_hit;
    end
  end
  assign active_out = active_q;
  assign evt_out    = evt_q;
  assign data_out   = shift_q;

  property p_act_set;
    @(posedge core_clk_in) disable iff (!rstn_in)
      first_low |=> active_q;
  endproperty
  a_act_set: assert property (p_act_set) else $error("active flag not set");
  property p_act_clr;
    @(posedge core_clk_in) disable iff (!rstn_in)
      (idle_hit && !first_low) |=> !active_q ##1 evt_q.idle_seen == 1'b0;
  endproperty
  a_act_clr: assert property (p_act_clr) else $error("active flag not cleared");
  property p_ferr;
    @(posedge core_clk_in) disable iff (!rstn_in)
      (mid && state_q == RX_STOP) |=> (evt_q.frame_err == !$past(line_in)) && evt_q.byte_valid;
  endproperty
  a_ferr: assert property (p_ferr) else $error("framing error wrong");
endmodule // serial_rx_core

/* tb/serial_far_end.sv */
// far-end transceiver model: drives the receive pin, decodes the transmit pin
`timescale 1ns/1ps
module serial_far_end #(
  parameter int BIT_CLKS = 32  // clocks in one bit time
) (
  // clock
  input  wire logic core_clk_in,
  // pins seen from the far side
  input  wire logic line_in,   // block transmit pin
  output logic      line_out   // block receive pin
);
  // line rests at mark until a frame is sent
  initial line_out = 1'b1;

  // parks the receive pin at a given resting level
  task automatic rest(input logic lvl);
    line_out <= lvl;
  endtask

  // sends start, eight data bits lsb first and the given stop level
  task automatic send_frame(input logic [7:0] b, input logic stop, input logic inv);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i] ^ inv;
      repeat (BIT_CLKS) @(posedge core_clk_in);
    end
    line_out <= ~inv; // back to idle mark
  endtask

  // waits for a start level, then samples each data bit in its middle
  task automatic get_frame(input logic inv, output logic [7:0] b);
    int n;
    n = 0;
    while ((line_in ^ inv) !== 1'b0 && n < 4 * BIT_CLKS) begin
      @(posedge core_clk_in);
      n++;
    end
    repeat (BIT_CLKS / 2) @(posedge core_clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge core_clk_in);
      b[i] = line_in ^ inv;
    end
  endtask
endmodule // serial_far_end

/* tb/serial_line_polarity_status_tb_top.sv */
// self-checking bench for the serial status block with a queue of expected bytes
`timescale 1ns/1ps
`include "serial_defines.svh"
module serial_line_polarity_status_tb_top;
  import serial_pkg::*;
  localparam int DIV = 2;        // baud divisor used for traffic
  localparam int BT  = 16 * DIV; // clocks per bit
  logic        core_clk_in;      // bench clock
  logic        rstn_in;          // active-low reset
  reg_req_type req;              // register request
  logic [7:0]  rdata;            // read data
  logic        txd_out;          // transmit pin level
  logic        txd_oe_out;       // transmit pin enable
  logic        txd_in;           // transmit pin as seen on the wire
  logic        rxd_in;           // receive pin
  logic        irq_out;          // interrupt
  int          n_errors;         // mismatches
  int          checks_done;      // comparisons
  int          cnt;              // scratch count
  logic [7:0]  rv;               // scratch read value
  logic [7:0]  b;                // scratch byte
  logic [7:0]  exp_q[$];         // bytes the receiver should deliver

  // pin is pulled up when the block releases it
  assign txd_in = txd_oe_out ? txd_out : 1'b1;

  serial_line_polarity_status dut_u (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .reg_req_in(req), .reg_rdata_out(rdata),
    .txd_in(txd_in), .txd_out(txd_out), .txd_oe_out(txd_oe_out), .rxd_in(rxd_in),
    .irq_out(irq_out));
  serial_far_end #(.BIT_CLKS(BT)) far_u (
    .core_clk_in(core_clk_in), .line_in(txd_out), .line_out(rxd_in));

  // clock generator
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end

  // compares one design value
  task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  // compares one measured count
  task automatic chkn(input string what, input int e, input int g);
    checks_done++;
    if (g != e) begin
      n_errors++;
      $display("unexpected %s: expected %0d seen %0d", what, e, g);
    end
  endtask
  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk_in);
    req <= '0;
  endtask
  // one-cycle read, data taken in the following cycle, masked and compared
  task automatic rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e,
                    input string what);
    @(posedge core_clk_in);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk_in);
    req <= '0;
    #1 rv = rdata;
    chk8(what, e, rv & m);
  endtask
  // verdict and end of run
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (40000) @(posedge core_clk_in);
    n_errors++;
    end_of_test();
  end

  // main sequence
  initial begin
    req = '0;
    rstn_in = 1'b0;
    n_errors = 0;
    checks_done = 0;
    void'($urandom(34));
    repeat (8) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    // default map and read-only activity bit
    rc(`OFF_SLOT0, 8'hff, 8'(`BAUD_HI_RST), "baud high");
    rc(`OFF_SLOT1, 8'hff, `BAUD_LO_RST, "baud low");
    rc(`OFF_SLOT2, 8'hff, `CTRL_RST, "control one");
    wr(`OFF_STATUS2, 8'h01);
    rc(`OFF_STATUS2, 8'hff, 8'h00, "status two");
    // alternate map hides baud and control one
    wr(`OFF_STATUS2, 8'h80);
    rc(`OFF_STATUS2, 8'hff, 8'h80, "status two");
    wr(`OFF_SLOT0, 8'hff);
    rc(`OFF_SLOT0, 8'hff, 8'h01, "alt status one");
    rc(`OFF_SLOT1, 8'hff, 8'h00, "alt control one");
    rc(`OFF_SLOT2, 8'hff, 8'h00, "alt control two");
    wr(`OFF_STATUS2, 8'h00);
    rc(`OFF_SLOT0, 8'hff, 8'h00, "baud high");
    rc(4'h9, 8'hff, 8'h00, "unmapped");
    wr(`OFF_SLOT1, 8'(DIV));
    rc(`OFF_SLOT1, 8'hff, 8'(DIV), "baud low");
    // nrz transmit in both polarities
    for (int p = 0; p < 2; p++) begin
      wr(`OFF_STATUS2, 8'(p << 4));
      repeat (2) @(posedge core_clk_in);
      chk8("tx idle", 8'(p ^ 1), {7'b0, txd_out});
      b = 8'($urandom);
      wr(`OFF_DATA, b);
      far_u.get_frame(p[0], rv);
      chk8("tx byte", b, rv);
      repeat (3 * BT) @(posedge core_clk_in);
      rc(`OFF_IRQ_STAT, 8'h01, 8'h01, "tx done");
      wr(`OFF_IRQ_CLR, 8'hff);
    end
    // break length, short and long
    for (int l = 0; l < 2; l++) begin
      wr(`OFF_STATUS2, 8'(l << 2));
      wr(`OFF_COMMAND, 8'h01);
      cnt = 0;
      while (txd_out !== 1'b0 && cnt < 4 * BT) begin
        @(posedge core_clk_in);
        cnt++;
      end
      cnt = 0;
      while (txd_out === 1'b0 && cnt < 20 * BT) begin
        @(posedge core_clk_in);
        cnt++;
      end
      chkn("break bits", (l != 0) ? 13 : 10, (cnt + BT / 2) / BT);
      repeat (2 * BT) @(posedge core_clk_in);
    end
    // infrared transmit: pulse clocks per zero bit, both polarities
    wr(`OFF_SLOT2, 8'h02);
    for (int p = 0; p < 2; p++) begin
      wr(`OFF_STATUS2, 8'(p << 4));
      repeat (2) @(posedge core_clk_in);
      chk8("ir idle", 8'(p), {7'b0, txd_out});
      b = 8'($urandom);
      wr(`OFF_DATA, b);
      cnt = 0;
      repeat (11 * BT) begin
        @(posedge core_clk_in);
        if (txd_out !== p[0]) cnt++;
      end
      chkn("ir pulse clocks", 3 * DIV * (9 - $countones(b)), cnt);
    end
    wr(`OFF_SLOT2, 8'h00);
    repeat (12 * BT) @(posedge core_clk_in);
    // receive in both polarities, activity flag set then cleared by idle
    for (int p = 0; p < 2; p++) begin
      wr(`OFF_STATUS2, 8'((p << 3) | (p << 2)));
      b = 8'($urandom);
      exp_q.push_back(b);
      fork
        far_u.send_frame(b, 1'b1, p[0]);
        begin
          repeat (BT / 2) @(posedge core_clk_in);
          rc(`OFF_STATUS2, 8'h01, 8'h01, "rx active");
        end
      join
      repeat (BT) @(posedge core_clk_in);
      rc(`OFF_DATA, 8'hff, exp_q.pop_front(), "rx byte");
      repeat (11 * BT) @(posedge core_clk_in);
      rc(`OFF_STATUS2, 8'h01, 8'h00, "rx active");
    end
    // framing error alike for both break lengths
    for (int l = 0; l < 2; l++) begin
      wr(`OFF_STATUS2, 8'(l << 2));
      far_u.rest(1'b1);
      wr(`OFF_IRQ_CLR, 8'hff);
      far_u.send_frame(8'($urandom), 1'b0, 1'b0);
      repeat (BT) @(posedge core_clk_in);
      rc(`OFF_IRQ_STAT, 8'h04, 8'h04, "framing error");
    end
    // interrupt raised, masked and cleared
    repeat (12 * BT) @(posedge core_clk_in);
    wr(`OFF_IRQ_EN, 8'h02);
    wr(`OFF_IRQ_CLR, 8'hff);
    repeat (2) @(posedge core_clk_in);
    chk8("irq idle", 8'h00, {7'b0, irq_out});
    far_u.send_frame(8'h3c, 1'b1, 1'b0);
    repeat (BT) @(posedge core_clk_in);
    chk8("irq raised", 8'h01, {7'b0, irq_out});
    wr(`OFF_IRQ_EN, 8'h00);
    repeat (2) @(posedge core_clk_in);
    chk8("irq masked", 8'h00, {7'b0, irq_out});
    wr(`OFF_IRQ_CLR, 8'h02);
    wr(`OFF_IRQ_EN, 8'h02);
    repeat (2) @(posedge core_clk_in);
    chk8("irq cleared", 8'h00, {7'b0, irq_out});
    // single-wire pin direction
    wr(`OFF_SLOT2, 8'h01);
    for (int d = 0; d < 2; d++) begin
      wr(`OFF_STATUS2, 8'(d << 1));
      repeat (2) @(posedge core_clk_in);
      chk8("pin enable", 8'(d), {7'b0, txd_oe_out});
    end
    wr(`OFF_STATUS2, 8'h00);
    wr(`OFF_SLOT2, 8'h00);
    repeat (2) @(posedge core_clk_in);
    chk8("pin enable", 8'h01, {7'b0, txd_oe_out});
    end_of_test();
  end
endmodule // serial_line_polarity_status_tb_top
